// >>> common/mcb_pkg.sv
// Constants and carrier types for the multi-device channel bonding block
package mcb_pkg;
	// ==========================================================
	// Bond status bus line codes
	localparam logic [1:0] BOND_RSVD = 2'h0;
	localparam logic [1:0] BOND_ADD = 2'h1;
	localparam logic [1:0] BOND_DEL = 2'h2;
	localparam logic [1:0] BOND_NORM = 2'h3;

	// ==========================================================
	// Geometry and register map (byte addresses)
	localparam int NCH = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [31:0] RDATA_RESET = 32'h00000000;

	// ==========================================================
	// Pin synchroniser: {bondStatus[1:0], allBonded, role, hold_n, selD, selB}
	localparam int PIN_W = 7;
	localparam logic [6:0] PIN_SYNC_RST = 7'h74;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [3:0] members;
		logic rxClkIsRef;
		logic quadBondEn;
	} mcb_ctrl_s;

	typedef struct packed {
		logic [3:0] bondSeqDet;
		logic [3:0] framingValid;
		logic [1:0] lineCode;
		logic [1:0] masterIdx;
		logic allBondedLine;
		logic resolved;
		logic driving;
		logic isMaster;
	} mcb_stat_s;

	typedef struct packed {
		logic [3:0] framingValid;
		logic [3:0] bondSeqDet;
		logic [3:0] ebAdd;
		logic [3:0] ebDel;
	} mcb_chan_s;
endpackage

// >>> verification/mcb_peer_model.sv
// Peer transceiver model sharing the bond status and all-bonded lines
`timescale 1ns/1ps
`default_nettype none
module mcb_peer_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic peerMaster,
	input wire logic [1:0] peerCode,
	input wire logic peerFramed,
	output logic [1:0] peerBus_b,
	output logic peerAll_b
);
	// =======
	// Released lines read high through the pull-up, so 11 means let go
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			peerBus_b <= 2'h3;
			peerAll_b <= 1'b1;
		end else begin
			peerBus_b <= peerMaster ? peerCode : 2'h3;
			peerAll_b <= peerFramed;
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the multi-device channel bonding block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import mcb_pkg::*;
;
	logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, chAlignPermit;
	logic [31:0] avs_writedata, avs_readdata, rdata;
	mcb_chan_s chanIn;
	logic [1:0] bondStatusIn, bondStatusOut, bondStatusOe_b;
	logic allBondedIn, allBondedOut, allBondedOe_b, deviceRoleSelect;
	logic offsetAdjustHold_n, masterChannelSelB, masterChannelSelD;
	logic slaveEbAdd, slaveEbDel, peerMaster, peerFramed, peerAll_b;
	logic [1:0] peerCode, peerBus_b;
	int mismatches, testsRun;

	// =======
	// Open-drain lines: low when any party pulls
	assign bondStatusIn = bondStatusOe_b & peerBus_b;
	assign allBondedIn = allBondedOe_b & peerAll_b;

	mcb_bond_ctrl i_mcb_bond_ctrl (
		.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .chanIn,
		.bondStatusIn, .bondStatusOut, .bondStatusOe_b, .allBondedIn,
		.allBondedOut, .allBondedOe_b, .deviceRoleSelect,
		.offsetAdjustHold_n, .masterChannelSelB, .masterChannelSelD,
		.chAlignPermit, .slaveEbAdd, .slaveEbDel
	);
	mcb_peer_model i_mcb_peer_model (
		.ref_clk, .rst_b, .peerMaster, .peerCode, .peerFramed,
		.peerBus_b, .peerAll_b
	);

	// =======
	// Shared tasks
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Waitrequest and read data are taken at the edge that ends the wait
	task automatic bus(input logic wr, input logic [3:0] a,
			input logic [31:0] d);
		int n;
		logic w;
		n = 0;
		w = 1'b1;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		while (w && n < 20) begin
			@(posedge ref_clk);
			w = avs_waitrequest;
			rdata = avs_readdata;
			n++;
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (w) begin
			mismatches++;
			give_verdict();
		end
	endtask

	task automatic pins(input logic r, input logic h, input logic [1:0] s);
		@(posedge ref_clk);
		deviceRoleSelect <= r;
		offsetAdjustHold_n <= h; // Peers see the same level
		{masterChannelSelD, masterChannelSelB} <= s;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic ebPulse(input logic [3:0] a, input logic [3:0] dl,
			input logic [1:0] exp);
		@(posedge ref_clk);
		chanIn.ebAdd <= a;
		chanIn.ebDel <= dl;
		@(posedge ref_clk);
		chanIn.ebAdd <= 4'h0;
		chanIn.ebDel <= 4'h0;
		#1;
		chk(32'(bondStatusOe_b), 32'(exp));
		chk(32'({bondStatusOut, allBondedOut}), 32'h0);
		@(posedge ref_clk);
		#1;
		chk(32'(bondStatusOe_b), 32'h3);
	endtask

	task automatic setCh(input logic [3:0] s, input logic [3:0] f);
		@(posedge ref_clk);
		chanIn.bondSeqDet <= s;
		chanIn.framingValid <= f;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	task automatic slaveCmd(input logic [1:0] c, input logic del);
		logic hit;
		hit = 1'b0;
		@(posedge ref_clk);
		peerCode <= c;
		@(posedge ref_clk);
		peerCode <= BOND_NORM;
		repeat (6) begin
			#1;
			hit = hit | (del ? slaveEbDel : slaveEbAdd);
			@(posedge ref_clk);
		end
		chk(32'(hit), 32'h1);
	endtask

	// =======
	// Scenarios
	task automatic t_master();
		bus(1'b1, REG_CTRL, 32'h3F);
		bus(1'b0, REG_CTRL, 32'h0);
		chk(rdata, 32'h3F);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(32'(rdata[5:0]), 32'h23);
		ebPulse(4'h4, 4'h0, BOND_ADD);
		ebPulse(4'h0, 4'h4, BOND_DEL);
		ebPulse(4'h4, 4'h4, BOND_ADD);
		ebPulse(4'hB, 4'hB, BOND_NORM);
		pins(1'b0, 1'b1, 2'h1);
		ebPulse(4'h2, 4'h0, BOND_ADD);
		pins(1'b0, 1'b1, 2'h2);
	endtask

	task automatic t_nodrive();
		bus(1'b1, REG_CTRL, 32'h3D);
		ebPulse(4'h4, 4'h0, BOND_NORM);
		chk(32'(allBondedOe_b), 32'h1);
		bus(1'b1, REG_CTRL, 32'h3E);
		ebPulse(4'h4, 4'h0, BOND_NORM);
		bus(1'b1, REG_CTRL, 32'h3B);
		ebPulse(4'h0, 4'h4, BOND_NORM);
	endtask

	task automatic t_bonded();
		bus(1'b1, REG_CTRL, 32'h3F);
		setCh(4'hF, 4'h7);
		chk(32'(allBondedOe_b), 32'h0);
		setCh(4'h7, 4'hF);
		chk(32'(allBondedOe_b), 32'h0);
		setCh(4'hF, 4'hF);
		chk(32'(allBondedOe_b), 32'h1);
		@(posedge ref_clk);
		peerFramed <= 1'b0;
		repeat (4) @(posedge ref_clk);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(32'(rdata[3]), 32'h0);
		@(posedge ref_clk);
		peerFramed <= 1'b1;
	endtask

	task automatic t_permit();
		pins(1'b0, 1'b0, 2'h2);
		setCh(4'h7, 4'hF);
		chk(32'(chAlignPermit), 32'h0);
		setCh(4'hF, 4'hF);
		chk(32'(chAlignPermit), 32'hF);
		pins(1'b0, 1'b1, 2'h2);
		setCh(4'h5, 4'hF);
		chk(32'(chAlignPermit), 32'h5);
		bus(1'b1, REG_CTRL, 32'h2F);
		setCh(4'hF, 4'hF);
		chk(32'(chAlignPermit), 32'h0);
	endtask

	task automatic t_slave();
		bus(1'b1, REG_CTRL, 32'h3F);
		pins(1'b1, 1'b1, 2'h2);
		@(posedge ref_clk);
		peerMaster <= 1'b1;
		ebPulse(4'h4, 4'h0, BOND_NORM);
		slaveCmd(BOND_ADD, 1'b0);
		slaveCmd(BOND_DEL, 1'b1);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		mismatches = 0;
		testsRun = 0;
		rst_b = 1'b0;
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		chanIn = '0;
		deviceRoleSelect = 1'b0;
		offsetAdjustHold_n = 1'b1;
		{masterChannelSelD, masterChannelSelB} = 2'h2;
		{peerMaster, peerCode, peerFramed} = 4'h7;
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		#1;
		chk(32'(bondStatusOe_b), 32'h3);
		chk(32'(allBondedOe_b), 32'h1);
		bus(1'b1, 4'h8, 32'hFFFFFFFF);
		bus(1'b0, 4'h8, 32'h0);
		chk(rdata, 32'h0);
		bus(1'b0, REG_CTRL, 32'h0);
		chk(rdata, 32'h0);
		t_master();
		t_nodrive();
		t_bonded();
		t_permit();
		t_slave();
		give_verdict();
	end
endmodule
`default_nettype wire

// >>> verilog/mcb_bond_ctrl.sv
// Inter-device receive channel bonding control with Avalon-MM registers
// How it works
// RL1: Bus codes: 00 reserved, 01 add K28.5 after framing, 10 delete, 11 normal.
// RL2: Bus driven only as master, four channels bonded, receive clocked by ref.
// RL3: Bus values update on every character-rate clock edge.
// RL4: Master places its selected master channel's buffer status on the bus.
// RL5: Master channel picked by the two master channel select inputs.
// RL6: System wires master bus outputs to every slave's bus inputs.
// RL7: Role select low means master driving bus; high means slave listening.
// RL8: Role select ignored unless quad bonding and ref-clocked receive.
// RL9: All-bonded line is active high wired-AND, tied across the domain.
// RL10: All-bonded held low during resolution; released once all framed.
// RL11: All-bonded driven only with four-channel bonding and ref clocking.
// RL12: Hold low blocks offset moves until every bonded channel saw sequence.
// RL13: Hold high lets each channel with the sequence align its buffer.
// RL14: Bonding only when the master channel belongs to the group.
// RL15: System sets offset adjust hold equally on all devices.
// RL16: Slave applies received add or delete commands to its buffers.
`timescale 1ns/1ps
`default_nettype none
module mcb_bond_ctrl
	import mcb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire mcb_chan_s chanIn,
	input wire logic [1:0] bondStatusIn,
	output logic [1:0] bondStatusOut,
	output logic [1:0] bondStatusOe_b,
	input wire logic allBondedIn,
	output logic allBondedOut,
	output logic allBondedOe_b,
	input wire logic deviceRoleSelect,
	input wire logic offsetAdjustHold_n,
	input wire logic masterChannelSelB,
	input wire logic masterChannelSelD,
	output logic [3:0] chAlignPermit,
	output logic slaveEbAdd,
	output logic slaveEbDel
);
	// ==========================================================
	// Pin synchronisation
	logic [PIN_W-1:0] pinSync;
	logic [1:0] lineCode;
	logic allBondedLine;
	logic roleSync;
	logic holdSync_n;
	logic [1:0] masterIdx;

	mcb_sync2 #(
		.W(PIN_W),
		.RST_VAL(PIN_SYNC_RST)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.pinIn({bondStatusIn, allBondedIn, deviceRoleSelect,
			offsetAdjustHold_n, masterChannelSelD, masterChannelSelB}),
		.syncOut(pinSync)
	);

	always_comb begin
		lineCode = pinSync[6:5];
		allBondedLine = pinSync[4];
		roleSync = pinSync[3];
		holdSync_n = pinSync[2];
		masterIdx = pinSync[1:0]; // [RL5]
	end

	// ==========================================================
	// Register file and Avalon-MM slave
	mcb_ctrl_s ctrl_q;
	mcb_ctrl_s ctrl_d;
	mcb_stat_s stat;
	logic wait_d;
	logic [31:0] rdata_d;
	logic reqOn;
	logic accept;

	always_comb begin
		reqOn = avs_read | avs_write;
		accept = reqOn & ~avs_waitrequest;
		// One wait state, then a single acknowledge cycle
		wait_d = ~(reqOn & avs_waitrequest);
		rdata_d = avs_readdata;
		if (reqOn && avs_waitrequest) begin
			unique case (avs_address)
				REG_CTRL: rdata_d = {26'h0000000, ctrl_q};
				REG_STATUS: rdata_d = {16'h0000, stat};
				default: rdata_d = 32'h00000000;
			endcase
		end
		ctrl_d = ctrl_q;
		if (accept && avs_write && avs_address == REG_CTRL) begin
			ctrl_d = avs_writedata[5:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= CTRL_RESET;
			avs_waitrequest <= 1'b1;
			avs_readdata <= RDATA_RESET;
		end else begin
			ctrl_q <= ctrl_d;
			avs_waitrequest <= wait_d;
			avs_readdata <= rdata_d;
		end
	end

	// ==========================================================
	// Bonding decisions
	logic bondEnable;
	logic fourBonded;
	logic isMaster;
	logic isSlave;
	logic groupOk;
	logic allDet;
	logic allFramed;
	logic resolved;
	logic busDrive;
	logic [1:0] busCode;
	logic abDrive;

	always_comb begin
		// Role pin means nothing outside ref-clocked quad bonding
		bondEnable = ctrl_q.quadBondEn & ctrl_q.rxClkIsRef; // [RL8]
		fourBonded = bondEnable & (&ctrl_q.members); // [RL11]
		isMaster = bondEnable & ~roleSync; // [RL7]
		isSlave = bondEnable & roleSync; // [RL7]
		groupOk = ctrl_q.members[masterIdx]; // [RL14]
		allDet = &(chanIn.bondSeqDet | ~ctrl_q.members);
		allFramed = &(chanIn.framingValid | ~ctrl_q.members);
		resolved = groupOk & allDet;
		busDrive = isMaster & fourBonded; // [RL2]
		// Add takes priority should a channel flag both at once
		if (chanIn.ebAdd[masterIdx]) begin // [RL4]
			busCode = BOND_ADD; // [RL1]
		end else if (chanIn.ebDel[masterIdx]) begin
			busCode = BOND_DEL; // [RL1]
		end else begin
			busCode = BOND_NORM; // [RL1]
		end
		abDrive = fourBonded & ~(resolved & allFramed); // [RL10]
		stat = '{bondSeqDet: chanIn.bondSeqDet,
			framingValid: chanIn.framingValid, lineCode: lineCode,
			masterIdx: masterIdx, allBondedLine: allBondedLine,
			resolved: resolved, driving: busDrive, isMaster: isMaster};
	end

	// ==========================================================
	// Open-drain lines, registered every character clock
	mcb_od_drv #(
		.W(2)
	) u_status_drv (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.enable(busDrive), // [RL3]
		.level(busCode),
		.pinOut(bondStatusOut),
		.pinOe_b(bondStatusOe_b)
	);

	// Only ever pulls low, so the tied lines form a wired AND
	mcb_od_drv #(
		.W(1)
	) u_allbond_drv ( // [RL9]
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.enable(abDrive), // [RL11]
		.level(1'b0),
		.pinOut(allBondedOut),
		.pinOe_b(allBondedOe_b)
	);

	// ==========================================================
	// Offset alignment permits and slave buffer commands
	logic [3:0] permit_d;
	logic slvAdd_d;
	logic slvDel_d;

	always_comb begin
		permit_d = 4'h0;
		if (groupOk) begin // [RL14]
			if (!holdSync_n) begin
				permit_d = allDet ? ctrl_q.members : 4'h0; // [RL12]
			end else begin
				permit_d = chanIn.bondSeqDet & ctrl_q.members; // [RL13]
			end
		end
		// Reserved code is ignored; line skew adds sync latency
		slvAdd_d = isSlave & (lineCode == BOND_ADD); // [RL16]
		slvDel_d = isSlave & (lineCode == BOND_DEL); // [RL16]
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			chAlignPermit <= 4'h0;
			slaveEbAdd <= 1'b0;
			slaveEbDel <= 1'b0;
		end else begin
			chAlignPermit <= permit_d;
			slaveEbAdd <= slvAdd_d;
			slaveEbDel <= slvDel_d;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	codeAdd_a: assert property ( // [RL1] [RL4]
		busDrive && chanIn.ebAdd[masterIdx] |=> bondStatusOe_b == 2'h1)
		else $error("add code not driven");

	codeDel_a: assert property ( // [RL1]
		busDrive && !chanIn.ebAdd[masterIdx] && chanIn.ebDel[masterIdx]
		|=> bondStatusOe_b == 2'h2)
		else $error("delete code not driven");

	busRelease_a: assert property ( // [RL2]
		!(isMaster && fourBonded) |=> bondStatusOe_b == 2'h3)
		else $error("bus driven while not allowed");

	roleIgnored_a: assert property ( // [RL8]
		!bondEnable [*2] |=> bondStatusOe_b == 2'h3 && !slaveEbAdd
		&& !slaveEbDel)
		else $error("role acted on while bonding off");

	resolveLow_a: assert property ( // [RL10]
		fourBonded && !resolved |=> !allBondedOe_b)
		else $error("all-bonded not held low");

	abIdle_a: assert property ( // [RL11]
		!fourBonded |=> allBondedOe_b)
		else $error("all-bonded driven outside bonding");

	holdBlock_a: assert property ( // [RL12]
		!holdSync_n && !allDet |=> chAlignPermit == 4'h0)
		else $error("offset moved while held");

	holdFree_a: assert property ( // [RL13] [RL14]
		holdSync_n |=> chAlignPermit == ($past(groupOk) ?
		$past(chanIn.bondSeqDet & ctrl_q.members) : 4'h0))
		else $error("align permit wrong");

	slaveApply_a: assert property ( // [RL16]
		isSlave && lineCode == BOND_ADD |=> slaveEbAdd && !slaveEbDel)
		else $error("slave add not applied");

	busAck_a: assert property (
		reqOn && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest handshake broken");

	addSent_c: cover property (busDrive && busCode == BOND_ADD);
	slaveDel_c: cover property (slaveEbDel);
	allBonded_c: cover property (fourBonded && !abDrive);
	heldAlign_c: cover property (!holdSync_n && allDet && groupOk);
endmodule
`default_nettype wire

// >>> verilog/mcb_od_drv.sv
// Registered open-drain pin driver: pulls low, otherwise releases
`timescale 1ns/1ps
`default_nettype none
module mcb_od_drv #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic [W-1:0] level,
	output logic [W-1:0] pinOut,
	output logic [W-1:0] pinOe_b
);
	logic [W-1:0] oe_d;

	// Ones are never driven; the pull-up makes them
	always_comb begin
		oe_d = enable ? level : '1;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pinOut <= '0;
			pinOe_b <= '1;
		end else begin
			pinOut <= '0;
			pinOe_b <= oe_d;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/mcb_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module mcb_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = pinIn;
		sync_d = meta_q;
	end

	// First stage is read only by the second stage
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= RST_VAL;
			syncOut <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			syncOut <= sync_d;
		end
	end
endmodule
`default_nettype wire
